// ### design/epid_defines.svh
/*
 Offsets, field positions, reset values and timing counts of the
 external pin interrupt detector. Assumes inclusion by bare name.
*/
`ifndef EPID_DEFINES_SVH
`define EPID_DEFINES_SVH

`define EPID_CLK_HZ          10000000
`define EPID_HOLD_CYCLES     4
`define EPID_ADR_CTRL_A      4'h0
`define EPID_ADR_CTRL_B      4'h4
`define EPID_ADR_INT_EN      4'h8
`define EPID_ADR_STATUS      4'hC
`define EPID_CTRL_RESET      4'h0
`define EPID_INTEN_RESET     3'h0
`define EPID_BIT_SYNC_SEL    0
`define EPID_BIT_BOTH_EDGE   1
`define EPID_BIT_POLARITY    2
`define EPID_BIT_IN_ENABLE   3
`define EPID_BIT_EN_A        0
`define EPID_BIT_EN_B        1
`define EPID_BIT_GLOBAL      2
`define EPID_BIT_WAKE_A      0
`define EPID_BIT_WAKE_B      1
`define EPID_BIT_FLAG_A      0
`define EPID_BIT_FLAG_B      1

`endif

// ### design/epid_pin_detect.sv
/*
 One pin detector: synchroniser, level hold filter, gated edge detect.
 Assumes pin is asynchronous and control comes from clk_i registers.
*/
`include "epid_defines.svh"

module epid_pin_detect
   import epid_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          pin_i,
   input  wire epid_ctrl_type ctrl_i,
   output logic               event_o,
   output logic               level_o
);

   epid_det_type state;
   epid_det_type next_state;
   logic         gated;

   always_comb begin
      next_state = state;
      next_state.sync = {state.sync[0], pin_i};
      if (state.sync[1] == state.stable) begin
         next_state.hold = 3'h0;
      end else if (state.hold == 3'(`EPID_HOLD_CYCLES - 1)) begin
         next_state.stable = state.sync[1];
         next_state.hold   = 3'h0;
      end else begin
         next_state.hold = state.hold + 3'h1;
      end
      // gated level, control changes act as edges
      gated = ctrl_i.in_enable & (state.stable ~^ ctrl_i.polarity);
      next_state.gated_prev = gated;
   end

   always_comb begin
      if (ctrl_i.both_edge) begin
         event_o = gated ^ state.gated_prev;
      end else begin
         event_o = gated & ~state.gated_prev;
      end
   end

   assign level_o = state.stable;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

endmodule

// ### design/epid_pkg.sv
/*
 Types of the external pin interrupt detector.
 Assumes epid_defines.svh for numeric values.
*/
package epid_pkg;

   typedef struct packed {
      logic in_enable;
      logic polarity;
      logic both_edge;
      logic sync_sel;
   } epid_ctrl_type;

   typedef struct packed {
      logic [1:0] sync;
      logic [2:0] hold;
      logic       stable;
      logic       gated_prev;
   } epid_det_type;

endpackage

// ### design/epid_top.sv
/*
 External pin interrupt detector with two pins, request flags,
 enables and a classic Wishbone slave.
 Register map, byte offsets, fields in the low bits:
   0x0  pin A control: 3 input enable, 2 polarity, 1 both edges,
        0 timer sync (stored only)
   0x4  pin B control, same layout as pin A
   0x8  enables: 0 pin A, 1 pin B, 2 global;
        wakeup enables: 4 pin A, 5 pin B
   0xC  status: 0 flag A, 1 flag B, 2 level A, 3 level B;
        writing a one clears a flag
 A flag also clears on a skip test made while its pin enable is off, or on a taken interrupt; an event
 in the same cycle keeps it set. Every access is acknowledged in
 the cycle after it is taken; unmapped offsets read as zero.
 Assumes one 10 MHz clock and a CPU that pulses skip tests and
 interrupt acknowledges for one cycle each.
*/
`include "epid_defines.svh"

module epid_top
   import epid_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ext_irq_pin_a_i,
   input  wire logic        ext_irq_pin_b_i,
   input  wire logic        skip_test_flag_a_i,
   input  wire logic        skip_test_flag_b_i,
   input  wire logic        int_taken_a_i,
   input  wire logic        int_taken_b_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   output logic             skip_a_o,
   output logic             skip_b_o,
   output logic             irq_a_o,
   output logic             irq_b_o,
   output logic             irq_o,
   output logic             pin_a_wakeup_enable_o,
   output logic             pin_b_wakeup_enable_o
);

   typedef struct packed {
      epid_ctrl_type pin_a_control_reg;
      epid_ctrl_type pin_b_control_reg;
      logic [2:0]    interrupt_enable_reg;
      logic [1:0]    wake;
      logic          ext_req_flag_a;
      logic          ext_req_flag_b;
      logic          ack;
      logic [31:0]   rdata;
   } epid_state_type;

   epid_state_type state;
   epid_state_type next_state;
   logic           ev_a;
   logic           ev_b;
   logic           lvl_a;
   logic           lvl_b;
   logic           req;
   logic           wr;
   logic           clr_a;
   logic           clr_b;

   function automatic logic take(input logic flag, input logic en, input logic glb);
      take = flag & en & glb;
   endfunction

   // Skip test answers only while the interrupt is not enabled
   function automatic logic skip_hit(input logic strobe,
                                     input logic flag,
                                     input logic en);
      skip_hit = strobe & flag & ~en;
   endfunction

   // pin A enable and polarity feed detector
   epid_pin_detect u_det_a (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (ext_irq_pin_a_i),
      .ctrl_i  (state.pin_a_control_reg),
      .event_o (ev_a),
      .level_o (lvl_a)
   );

   // pin B enable and polarity feed detector
   epid_pin_detect u_det_b (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (ext_irq_pin_b_i),
      .ctrl_i  (state.pin_b_control_reg),
      .event_o (ev_b),
      .level_o (lvl_b)
   );

   // Every access acked one cycle after it is taken
   assign req = cyc_i & stb_i & ~state.ack;
   assign wr  = req & we_i & sel_i[0];

   assign clr_a = skip_a_o | (int_taken_a_i & irq_a_o);
   assign clr_b = skip_b_o | (int_taken_b_i & irq_b_o);

   always_comb begin
      next_state     = state;
      next_state.ack = req;
      // Register writes
      if (wr) begin
         unique case (adr_i)
            `EPID_ADR_CTRL_A: begin
               next_state.pin_a_control_reg = dat_i[3:0];
            end
            `EPID_ADR_CTRL_B: begin
               next_state.pin_b_control_reg = dat_i[3:0];
            end
            `EPID_ADR_INT_EN: begin
               next_state.interrupt_enable_reg = dat_i[2:0];
               next_state.wake                 = dat_i[5:4];
            end
            `EPID_ADR_STATUS: begin
               // Write one clears; an event below still wins
               if (dat_i[`EPID_BIT_FLAG_A]) begin
                  next_state.ext_req_flag_a = 1'b0;
               end
               if (dat_i[`EPID_BIT_FLAG_B]) begin
                  next_state.ext_req_flag_b = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      // clear on skip or interrupt taken
      if (clr_a) begin
         next_state.ext_req_flag_a = 1'b0;
      end
      if (clr_b) begin
         next_state.ext_req_flag_b = 1'b0;
      end
      // Set wins over clear
      // pin A event, control changes too
      if (ev_a) begin
         next_state.ext_req_flag_a = 1'b1;
      end
      // pin B event, control changes too
      if (ev_b) begin
         next_state.ext_req_flag_b = 1'b1;
      end
      // Read data, registered
      next_state.rdata = 32'h0;
      if (req & ~we_i) begin
         unique case (adr_i)
            `EPID_ADR_CTRL_A: next_state.rdata = {28'h0, state.pin_a_control_reg};
            `EPID_ADR_CTRL_B: next_state.rdata = {28'h0, state.pin_b_control_reg};
            `EPID_ADR_INT_EN: next_state.rdata = {26'h0, state.wake, 1'b0,
                                                  state.interrupt_enable_reg};
            `EPID_ADR_STATUS: next_state.rdata = {28'h0, lvl_b, lvl_a,
                                                  state.ext_req_flag_b,
                                                  state.ext_req_flag_a};
            default:          next_state.rdata = 32'h0;
         endcase
      end
   end

   assign irq_a_o = take(state.ext_req_flag_a,
                         state.interrupt_enable_reg[`EPID_BIT_EN_A],
                         state.interrupt_enable_reg[`EPID_BIT_GLOBAL]);
   assign irq_b_o = take(state.ext_req_flag_b,
                         state.interrupt_enable_reg[`EPID_BIT_EN_B],
                         state.interrupt_enable_reg[`EPID_BIT_GLOBAL]);
   // one level line for both pins
   assign irq_o   = irq_a_o | irq_b_o;
   // skip answers when interrupt enable is off
   assign skip_a_o = skip_hit(skip_test_flag_a_i, state.ext_req_flag_a,
                              state.interrupt_enable_reg[`EPID_BIT_EN_A]);
   assign skip_b_o = skip_hit(skip_test_flag_b_i, state.ext_req_flag_b,
                              state.interrupt_enable_reg[`EPID_BIT_EN_B]);

   assign ack_o    = state.ack;
   assign dat_o    = state.rdata;
   // Wakeup enables, stored for software
   assign pin_a_wakeup_enable_o = state.wake[`EPID_BIT_WAKE_A];
   assign pin_b_wakeup_enable_o = state.wake[`EPID_BIT_WAKE_B];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state                      <= '0;
         state.pin_a_control_reg    <= `EPID_CTRL_RESET;
         state.pin_b_control_reg    <= `EPID_CTRL_RESET;
         state.interrupt_enable_reg <= `EPID_INTEN_RESET;
      end else begin
         state <= next_state;
      end
   end

endmodule

// ### sim/epid_pin_src.sv
/*
 Model of the sources driving both interrupt pins.
 Assumes the bench clock; pins change just after rising edges.
*/
module epid_pin_src (
   input  wire logic       clk_i,
   output logic      [1:0] pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial pin_o = 2'h0;
   task automatic drive(input int idx, input logic val, input int hold);
      @(posedge clk_i);
      pin_o[idx] <= val;
      repeat (hold) @(posedge clk_i);
   endtask
endmodule

// ### sim/epid_top_props.sv
/*
 Checker on the ports of the pin interrupt detector.
 Assumes binding to epid_top at the foot of this file.
*/
module epid_top_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic skip_test_flag_a_i,
   input wire logic skip_test_flag_b_i,
   input wire logic int_taken_a_i,
   input wire logic skip_a_o,
   input wire logic skip_b_o,
   input wire logic irq_a_o,
   input wire logic irq_b_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_IRQ_OR: assert property (irq_o == (irq_a_o | irq_b_o))
      else $error("irq not the or of both lines");
   AST_ACK_ANS: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack missing");
   AST_ACK_ONE: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   AST_SKIP_A: assert property (skip_a_o |-> skip_test_flag_a_i)
      else $error("skip a without strobe");
   AST_SKIP_B: assert property (skip_b_o |-> skip_test_flag_b_i)
      else $error("skip b without strobe");
   AST_SKIP_EXCL: assert property (skip_b_o |-> !irq_b_o)
      else $error("skip while interrupt enabled");
   AST_IRQ_HOLD: assert property (irq_a_o && !int_taken_a_i && !skip_test_flag_a_i
      && !cyc_i |=> irq_a_o)
      else $error("flag a lost without clear");
endmodule
bind epid_top epid_top_props epid_top_props_inst (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .skip_test_flag_a_i(skip_test_flag_a_i),
   .skip_test_flag_b_i(skip_test_flag_b_i), .int_taken_a_i(int_taken_a_i),
   .skip_a_o(skip_a_o), .skip_b_o(skip_b_o), .irq_a_o(irq_a_o), .irq_b_o(irq_b_o),
   .irq_o(irq_o));

// ### sim/epid_top_test.sv
/*
 Self-checking bench of the pin interrupt detector.
 Assumes the pin source model and the bound checker.
*/
module epid_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic        ack_o, skip_a_o, skip_b_o, irq_a_o, irq_b_o, irq_o, wk_a, wk_b;
   logic [1:0]  skip = 0, taken = 0, pins;
   logic [3:0]  adr_i = 0, sel_i = 4'hF;
   logic [31:0] dat_i = 0, dat_o, q, fb;
   int          err_count = 0, comparisons = 0;
   always #50 clk_i = ~clk_i;
   epid_pin_src epid_pin_src_inst (.clk_i(clk_i), .pin_o(pins));
   epid_top epid_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ext_irq_pin_a_i(pins[0]),
      .ext_irq_pin_b_i(pins[1]), .skip_test_flag_a_i(skip[0]), .skip_test_flag_b_i(skip[1]),
      .int_taken_a_i(taken[0]), .int_taken_b_i(taken[1]), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .skip_a_o(skip_a_o), .skip_b_o(skip_b_o), .irq_a_o(irq_a_o), .irq_b_o(irq_b_o),
      .irq_o(irq_o), .pin_a_wakeup_enable_o(wk_a), .pin_b_wakeup_enable_o(wk_b));
   task automatic stop_test;
      $display("comparisons %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hF);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= s;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
      wb(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask
   // Strobe k: 0 skip test, 1 interrupt taken
   task automatic pulse(input int k, input int i, input logic e);
      @(posedge clk_i);
      if (k == 0) skip[i] <= 1'b1;
      else taken[i] <= 1'b1;
      @(negedge clk_i);
      chk("skip", 32'(e), 32'({skip_b_o, skip_a_o} >> i) & 32'h1);
      @(posedge clk_i);
      skip[i] <= 1'b0;
      taken[i] <= 1'b0;
      @(negedge clk_i);
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      stop_test;
   end
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a < 16; a += 2) rd(4'(a), 32'h0, "reset");
      chk("wake", 32'h0, {30'h0, wk_b, wk_a});
      $display("test reset done");
      for (int i = 0; i < 2; i++) begin
         fb = 32'h1 << i;
         wb(1'b1, 4'(i * 4), 32'h8);
         repeat (12) @(posedge clk_i);
         rd(4'hC, fb, "flag_enable");
         pulse(0, i, 1'b1);
         rd(4'hC, 32'h0, "flag_skip");
         epid_pin_src_inst.drive(i, 1'b1, 12);
         rd(4'hC, fb << 2, "no_rise");
         wb(1'b1, 4'(i * 4), 32'hC);
         repeat (12) @(posedge clk_i);
         rd(4'hC, fb | fb << 2, "flag_pol");
         pulse(0, i, 1'b1);
         epid_pin_src_inst.drive(i, 1'b0, 1);
         epid_pin_src_inst.drive(i, 1'b1, 12);
         rd(4'hC, fb << 2, "glitch");
         epid_pin_src_inst.drive(i, 1'b0, 6);
         epid_pin_src_inst.drive(i, 1'b1, 12);
         wb(1'b1, 4'h8, fb);
         chk("irq_local", 32'h0, 32'(irq_o));
         wb(1'b1, 4'h8, fb | 32'h4);
         chk("irq_global", 32'h1, 32'(irq_o));
         chk("irq_line", fb, {30'h0, irq_b_o, irq_a_o});
         pulse(1, i, 1'b0);
         chk("irq_taken", 32'h0, 32'(irq_o));
         wb(1'b1, 4'h8, 32'h0);
         epid_pin_src_inst.drive(i, 1'b0, 12);
         rd(4'hC, 32'h0, "fall_ignored");
         $display("test pin %0d done", i);
      end
      rd(4'h0, 32'hC, "ctrl_a");
      rd(4'h2, 32'h0, "unmapped");
      wb(1'b1, 4'h0, 32'hE);
      epid_pin_src_inst.drive(0, 1'b1, 12);
      rd(4'hC, 32'h5, "both_rise");
      wb(1'b1, 4'hC, 32'h1);
      rd(4'hC, 32'h4, "status_w1c");
      epid_pin_src_inst.drive(0, 1'b0, 12);
      rd(4'hC, 32'h1, "both_fall");
      $display("test both edges done");
      wb(1'b1, 4'h8, 32'h30);
      chk("wake", 32'h3, {30'h0, wk_b, wk_a});
      wb(1'b1, 4'h8, 32'h0);
      chk("wake", 32'h0, {30'h0, wk_b, wk_a});
      wb(1'b1, 4'h8, 32'h30, 4'h0);
      chk("wake_sel", 32'h0, {30'h0, wk_b, wk_a});
      $display("test wake done");
      stop_test;
   end
endmodule
